// ---- capture_input_filter_prescaler.sv ----
// Contract
// R1: sampled at the set rate, a new level needs a run of equal samples.
// R2: filter code 0 bypasses; codes 1-3 need 2, 4 or 8 samples at clk rate.
// R3: 4-9: 6 or 8 samples at dead-time /2 /4 /8; 10-15: 5, 6, 8 at /16 /32.
// R4: the two-bit edge divider gives one capture per 1, 2, 4 or 8 edges.
// R5: channel two's edge divider stays reset while chan_two_enable is low.
// R6: channel two: filter code 7:4, edge divider 3:2, mode select 1:0.
// R7: channel three: filter code 15:12, edge divider 11:10, mode select 9:8.
// R8: channel three filter and divider behave as those of channel two.
// R9: software writes the reserved bits 31:16 only with zero.
// R10: mode select uses the same encoding here as in the compare layout.
// R11: mode 00 output, 01 own filtered, 10 neighbour filtered, 11 trigger.
// R12: a mode select takes a write only while its channel enable is low.
// R13: a differing sample restarts the run; only chosen filtered edges count; here mode 11 counts edges of the unfiltered trigger.
// R14: reaching the edge count raises one capture and restarts the count.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module capture_input_filter_prescaler (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        chan_two_raw_input,
	input  wire logic        chan_three_raw_input,
	input  wire logic        internal_trigger_source,
	output logic             chan_two_capture,
	output logic             chan_three_capture
);
	import capture_cfg_pkg::*;

	// configuration and status state
	logic [15:0]      cfg;
	logic [15:0]      enables;
	logic [3:0]       two_events;
	logic [3:0]       three_events;
	logic [DIV_W-1:0] div_count;
	logic             two_prev;
	logic             three_prev;
	logic [15:0]      next_cfg;
	logic [15:0]      next_enables;
	logic [3:0]       next_two_events;
	logic [3:0]       next_three_events;

	// bus state
	logic             aw_held;
	logic             w_held;
	logic [3:0]       aw_addr;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;
	logic             next_aw_held;
	logic             next_w_held;
	logic [3:0]       next_aw_addr;
	logic [31:0]      next_w_data;
	logic [3:0]       next_w_strb;
	logic             next_awready;
	logic             next_wready;
	logic             next_bvalid;
	logic [1:0]       next_bresp;
	logic             next_arready;
	logic             next_rvalid;
	logic [31:0]      next_rdata;
	logic [1:0]       next_rresp;

	// decoded fields and datapath
	mode_e            two_mode;
	mode_e            three_mode;
	logic             two_level;
	logic             three_level;
	logic             two_sel;
	logic             three_sel;
	logic             two_edge;
	logic             three_edge;
	logic             aw_take;
	logic             w_take;
	logic             ar_take;
	logic             have_aw;
	logic             have_w;
	logic [3:0]       wr_addr;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;
	logic [31:0]      lane_mask;
	logic [15:0]      merged;

	always_comb begin
		two_mode   = mode_e'(cfg[TWO_MS_LSB +: 2]); // R6 R10
		three_mode = mode_e'(cfg[THREE_MS_LSB +: 2]); // R7 R10
	end

	// one filter per channel, both fed by the shared sampling divider
	input_noise_filter two_filter (
		.clk       (clk),
		.nrst      (nrst),
		.din       (chan_two_raw_input),
		.code      (cfg[TWO_FLT_LSB +: 4]), // R6
		.div_count (div_count),
		.level     (two_level)
	);

	input_noise_filter three_filter (
		.clk       (clk),
		.nrst      (nrst),
		.din       (chan_three_raw_input),
		.code      (cfg[THREE_FLT_LSB +: 4]), // R7 R8
		.div_count (div_count),
		.level     (three_level)
	);

	// capture source per mode; output mode feeds nothing
	always_comb begin
		case (two_mode)
			MODE_OWN:       two_sel = two_level; // R11
			MODE_NEIGHBOUR: two_sel = three_level;
			MODE_TRIGGER:   two_sel = internal_trigger_source;
			default:        two_sel = 1'b0;
		endcase
		case (three_mode)
			MODE_OWN:       three_sel = three_level; // R11
			MODE_NEIGHBOUR: three_sel = two_level;
			MODE_TRIGGER:   three_sel = internal_trigger_source;
			default:        three_sel = 1'b0;
		endcase
	end

	// polarity bit low picks rising edges, high picks falling
	always_comb begin
		two_edge = (two_mode != MODE_OUTPUT) && (enables[TWO_POL_BIT]
			? (two_prev && !two_sel) : (!two_prev && two_sel)); // R13
		three_edge = (three_mode != MODE_OUTPUT) && (enables[THREE_POL_BIT]
			? (three_prev && !three_sel) : (!three_prev && three_sel)); // R13
	end

	edge_prescaler two_divider (
		.clk       (clk),
		.nrst      (nrst),
		.enable    (enables[TWO_EN_BIT]), // R5
		.edge_seen (two_edge),
		.code      (cfg[TWO_DIV_LSB +: 2]), // R6
		.capture   (chan_two_capture)
	);

	edge_prescaler three_divider (
		.clk       (clk),
		.nrst      (nrst),
		.enable    (enables[THREE_EN_BIT]), // R8
		.edge_seen (three_edge),
		.code      (cfg[THREE_DIV_LSB +: 2]), // R7
		.capture   (chan_three_capture)
	);

	// write path: address and data may arrive in either order
	always_comb begin
		aw_take      = s_axi_awvalid && s_axi_awready;
		w_take       = s_axi_wvalid && s_axi_wready;
		have_aw      = aw_held || aw_take;
		have_w       = w_held || w_take;
		wr_addr      = aw_take ? s_axi_awaddr[3:0] : aw_addr;
		wr_data      = w_take ? s_axi_wdata : w_data;
		wr_strb      = w_take ? s_axi_wstrb : w_strb;
		lane_mask    = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
			{8{wr_strb[1]}}, {8{wr_strb[0]}}};
		next_aw_held = have_aw;
		next_w_held  = have_w;
		next_aw_addr = aw_take ? s_axi_awaddr[3:0] : aw_addr;
		next_w_data  = wr_data;
		next_w_strb  = wr_strb;
		next_bvalid  = s_axi_bvalid && !s_axi_bready;
		next_bresp   = s_axi_bresp;
		next_cfg     = cfg;
		next_enables = enables;
		merged       = 16'h0000;
		if (have_aw && have_w && !s_axi_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			case (wr_addr)
				CFG_OFFSET: begin
					// upper half is reserved and never stored
					merged = (cfg & ~lane_mask[15:0])
						| (wr_data[15:0] & lane_mask[15:0]); // R9
					next_cfg = merged;
					if (enables[TWO_EN_BIT])
						next_cfg[TWO_MS_LSB +: 2] = cfg[TWO_MS_LSB +: 2]; // R12
					if (enables[THREE_EN_BIT])
						next_cfg[THREE_MS_LSB +: 2] =
							cfg[THREE_MS_LSB +: 2]; // R12
				end
				ENABLE_OFFSET: begin
					merged = (enables & ~lane_mask[15:0])
						| (wr_data[15:0] & lane_mask[15:0]);
					next_enables = merged & ENABLE_MASK;
				end
				STATUS_OFFSET: ;
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	// read path: one read at a time, answered the cycle after the take
	always_comb begin
		ar_take      = s_axi_arvalid && s_axi_arready;
		next_rvalid  = s_axi_rvalid && !s_axi_rready;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (ar_take) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			case (s_axi_araddr[3:0])
				CFG_OFFSET:    next_rdata = {16'h0000, cfg};
				ENABLE_OFFSET: next_rdata = {16'h0000, enables};
				STATUS_OFFSET: begin
					next_rdata = 32'h0000_0000;
					next_rdata[TWO_LVL_BIT]        = two_level;
					next_rdata[THREE_LVL_BIT]      = three_level;
					next_rdata[TWO_CNT_LSB +: 4]   = two_events;
					next_rdata[THREE_CNT_LSB +: 4] = three_events;
				end
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	// capture counters wrap; they only show software that captures occur
	always_comb begin
		next_two_events   = two_events + {3'h0, chan_two_capture};
		next_three_events = three_events + {3'h0, chan_three_capture};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg           <= CFG_RESET;
			enables       <= ENABLE_RESET;
			two_events    <= 4'h0;
			three_events  <= 4'h0;
			div_count     <= '0;
			two_prev      <= 1'b0;
			three_prev    <= 1'b0;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			cfg           <= next_cfg;
			enables       <= next_enables;
			two_events    <= next_two_events;
			three_events  <= next_three_events;
			div_count     <= div_count + 1'b1; // R3
			two_prev      <= two_sel;
			three_prev    <= three_sel;
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	a_mode_locked: assert property (@(posedge clk) disable iff (!nrst)
		enables[TWO_EN_BIT] && $past(enables[TWO_EN_BIT])
		|-> cfg[1:0] == $past(cfg[1:0])) // R12
		else $error("channel two mode changed while enabled");
	a_mode_three_lock: assert property (@(posedge clk) disable iff (!nrst)
		enables[THREE_EN_BIT] && $past(enables[THREE_EN_BIT])
		|-> cfg[9:8] == $past(cfg[9:8])) // R12
		else $error("channel three mode changed while enabled");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
		s_axi_rvalid && s_axi_rresp == RESP_OKAY
		|-> s_axi_rdata[31:16] == 16'h0000) // R9
		else $error("reserved upper bits read nonzero");
	a_output_nocap: assert property (@(posedge clk) disable iff (!nrst)
		$past(two_mode) == MODE_OUTPUT |-> !chan_two_capture) // R11
		else $error("capture raised in output mode");
	a_edge_polarity: assert property (@(posedge clk) disable iff (!nrst)
		two_edge |-> two_sel == !enables[TWO_POL_BIT]) // R13
		else $error("edge of the wrong polarity counted");
	a_read_hold: assert property (@(posedge clk) disable iff (!nrst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read answer dropped before it was taken");
	a_write_answer: assert property (@(posedge clk) disable iff (!nrst)
		aw_take && w_take && !s_axi_bvalid |=> s_axi_bvalid)
		else $error("write not answered one cycle after both halves");
	a_three_single: assert property (@(posedge clk) disable iff (!nrst)
		chan_three_capture && cfg[11:10] != 2'b00
		|=> !chan_three_capture) // R14
		else $error("divided capture lasted two cycles");

	c_two_capture: cover property (@(posedge clk) disable iff (!nrst)
		chan_two_capture && cfg[3:2] == 2'b11);
	c_three_neighbour: cover property (@(posedge clk) disable iff (!nrst)
		chan_three_capture && three_mode == MODE_NEIGHBOUR);
	c_slow_filter: cover property (@(posedge clk) disable iff (!nrst)
		two_level != $past(two_level) && cfg[7:4] == 4'hf);
	c_bad_write: cover property (@(posedge clk) disable iff (!nrst)
		s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule : capture_input_filter_prescaler
`default_nettype wire

// ---- capture_cfg_pkg.sv ----
`default_nettype none
package capture_cfg_pkg;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [3:0]  CFG_OFFSET     = 4'h0;
	localparam logic [3:0]  ENABLE_OFFSET  = 4'h4;
	localparam logic [3:0]  STATUS_OFFSET  = 4'h8;

	// input-capture layout of channel_pair_input_config
	localparam int          TWO_MS_LSB     = 0;
	localparam int          TWO_DIV_LSB    = 2;
	localparam int          TWO_FLT_LSB    = 4;
	localparam int          THREE_MS_LSB   = 8;
	localparam int          THREE_DIV_LSB  = 10;
	localparam int          THREE_FLT_LSB  = 12;
	localparam logic [15:0] CFG_RESET      = 16'h0000;

	// channel_enable_register fields
	localparam int          TWO_EN_BIT     = 8;
	localparam int          TWO_POL_BIT    = 9;
	localparam int          THREE_EN_BIT   = 12;
	localparam int          THREE_POL_BIT  = 13;
	localparam logic [15:0] ENABLE_MASK    = 16'h3300;
	localparam logic [15:0] ENABLE_RESET   = 16'h0000;

	// status fields
	localparam int          TWO_LVL_BIT    = 0;
	localparam int          THREE_LVL_BIT  = 1;
	localparam int          TWO_CNT_LSB    = 8;
	localparam int          THREE_CNT_LSB  = 12;

	// axi responses
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	// sampling divider width: largest divide is 32
	localparam int          DIV_W          = 5;

	typedef enum logic [1:0] {
		MODE_OUTPUT    = 2'b00,
		MODE_OWN       = 2'b01,
		MODE_NEIGHBOUR = 2'b10,
		MODE_TRIGGER   = 2'b11
	} mode_e;

	// number of equal samples a filter code asks for
	function automatic logic [3:0] filter_samples(input logic [3:0] code);
		case (code)
			4'h1: filter_samples = 4'h2;
			4'h2: filter_samples = 4'h4;
			4'h4, 4'h6, 4'h8, 4'hb, 4'he: filter_samples = 4'h6;
			4'ha, 4'hd: filter_samples = 4'h5;
			default: filter_samples = 4'h8;
		endcase
	endfunction : filter_samples

	// log2 of the sampling divider; zero means kernel clock rate
	function automatic logic [2:0] filter_div_log(input logic [3:0] code);
		case (code)
			4'h4, 4'h5: filter_div_log = 3'h1;
			4'h6, 4'h7: filter_div_log = 3'h2;
			4'h8, 4'h9: filter_div_log = 3'h3;
			4'ha, 4'hb, 4'hc: filter_div_log = 3'h4;
			4'hd, 4'he, 4'hf: filter_div_log = 3'h5;
			default: filter_div_log = 3'h0;
		endcase
	endfunction : filter_div_log

endpackage : capture_cfg_pkg
`default_nettype wire

// ---- input_noise_filter.sv ----
`timescale 1ns/100ps
`default_nettype none
module input_noise_filter (
	input  wire logic                           clk,
	input  wire logic                           nrst,
	input  wire logic                           din,
	input  wire logic [3:0]                     code,
	input  wire logic [capture_cfg_pkg::DIV_W-1:0] div_count,
	output logic                                level
);
	import capture_cfg_pkg::*;

	logic       last;
	logic [3:0] cnt;
	logic       next_last;
	logic [3:0] next_cnt;
	logic       next_level;
	logic [3:0] need;
	logic [DIV_W-1:0] mask;
	logic       tick;

	// sample tick: low bits of the shared divider all ones
	always_comb begin
		need = filter_samples(code);
		mask = DIV_W'((6'h01 << filter_div_log(code)) - 6'h01);
		tick = ((div_count | ~mask) == {DIV_W{1'b1}}); // R3
	end

	// count equal samples; a differing one restarts the run
	always_comb begin
		next_last  = last;
		next_cnt   = cnt;
		next_level = level;
		if (code == 4'h0) begin
			next_level = din; // R2
			next_last  = din;
			next_cnt   = 4'h0;
		end else if (tick) begin
			if (din != last) begin
				next_last = din; // R13
				next_cnt  = 4'h1;
			end else begin
				if (cnt < need)
					next_cnt = cnt + 4'h1;
				if (cnt + 4'h1 >= need)
					next_level = din; // R1
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			last  <= 1'b0;
			cnt   <= 4'h0;
			level <= 1'b0;
		end else begin
			last  <= next_last;
			cnt   <= next_cnt;
			level <= next_level;
		end
	end

	a_filter_bypass: assert property (@(posedge clk) disable iff (!nrst)
		code == 4'h0 |=> level == $past(din)) // R2
		else $error("bypassed filter did not follow input");
	a_filter_change: assert property (@(posedge clk) disable iff (!nrst)
		(code != 4'h0 && $past(code) != 4'h0 && level != $past(level))
		|-> level == $past(din) && level == $past(last)) // R1
		else $error("filter accepted a level without a matching run");

endmodule : input_noise_filter
`default_nettype wire

// ---- edge_prescaler.sv ----
`timescale 1ns/100ps
`default_nettype none
module edge_prescaler (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       enable,
	input  wire logic       edge_seen,
	input  wire logic [1:0] code,
	output logic            capture
);
	import capture_cfg_pkg::*;

	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic       next_capture;
	logic [2:0] target;

	// one capture per 1, 2, 4 or 8 qualified edges
	always_comb begin
		target       = 3'((4'h1 << code) - 4'h1); // R4
		next_cnt     = cnt;
		next_capture = 1'b0;
		if (!enable) begin
			next_cnt = 3'h0; // R5
		end else if (edge_seen) begin
			// a count left above a lowered target still fires at once
			if (cnt >= target) begin
				next_capture = 1'b1; // R14
				next_cnt     = 3'h0;
			end else begin
				next_cnt = cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt     <= 3'h0;
			capture <= 1'b0;
		end else begin
			cnt     <= next_cnt;
			capture <= next_capture;
		end
	end

	a_presc_cleared: assert property (@(posedge clk) disable iff (!nrst)
		!enable |=> cnt == 3'h0 && !capture) // R5
		else $error("prescaler not held while channel disabled");
	a_presc_every: assert property (@(posedge clk) disable iff (!nrst)
		enable && edge_seen && code == 2'b00 |=> capture) // R4
		else $error("undivided edge gave no capture");
	a_presc_cause: assert property (@(posedge clk) disable iff (!nrst)
		capture |-> $past(edge_seen) && $past(enable)
		&& $past(cnt) >= 3'(({1'b0, $past(code)} == 3'h0) ? 0
		: (1 << $past(code)) - 1)) // R14
		else $error("capture without reaching the edge count");

endmodule : edge_prescaler
`default_nettype wire

// ---- input_pin_source.sv ----
`timescale 1ns/100ps
`default_nettype none
// far side of the block: two channel pins and the internal trigger line
module input_pin_source (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic want_two,
	input  wire logic want_three,
	input  wire logic want_trig,
	output logic      pin_two,
	output logic      pin_three,
	output logic      pin_trig
);
	// pins are synchronous to clk, so one register stands for the pad path;
	// a real pin is never unknown, hence the low park during reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_two   <= 1'b0;
			pin_three <= 1'b0;
			pin_trig  <= 1'b0;
		end else begin
			pin_two   <= want_two;
			pin_three <= want_three;
			pin_trig  <= want_trig;
		end
	end
endmodule : input_pin_source
`default_nettype wire

// ---- capture_input_filter_prescaler_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module capture_input_filter_prescaler_tb;
	import capture_cfg_pkg::*;
	logic        clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, cap_two, cap_three;
	logic        want_two, want_three, want_trig, pin_two, pin_three, pin_trig;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          err_count, tests_run, n_two, n_three;

	initial begin
		clk = 0;
		nrst = 0;
		awvalid = 0;
		wvalid = 0;
		bready = 0;
		arvalid = 0;
		rready = 0;
		awaddr = 0;
		wdata = 0;
		araddr = 0;
		wstrb = 4'hf;
		want_two = 0;
		want_three = 0;
		want_trig = 0;
		err_count = 0;
		tests_run = 0;
		n_two = 0;
		n_three = 0;
	end
	always #10 clk = ~clk;

	capture_input_filter_prescaler DUT (
		.clk(clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.chan_two_raw_input(pin_two), .chan_three_raw_input(pin_three),
		.internal_trigger_source(pin_trig),
		.chan_two_capture(cap_two), .chan_three_capture(cap_three)
	);

	input_pin_source src (
		.clk(clk), .nrst(nrst), .want_two(want_two), .want_three(want_three),
		.want_trig(want_trig), .pin_two(pin_two), .pin_three(pin_three),
		.pin_trig(pin_trig)
	);

	// capture pulses last one cycle, so every rising edge counts one
	always @(posedge clk) begin
		if (cap_two === 1'b1) n_two <= n_two + 1;
		if (cap_three === 1'b1) n_three <= n_three + 1;
	end

	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// handshakes are judged at the falling edge, where ready is already settled
	task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hit, w_hit, done;
		int   k;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		for (k = 0; k < 50 && !done; k++) begin
			@(negedge clk);
			aw_hit = awvalid & awready;
			w_hit = wvalid & wready;
			done = bvalid;
			if (done) chk("bresp", {30'h0, er}, {30'h0, bresp});
			@(posedge clk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
		if (!done) chk("write answer", 32'h1, 32'h0);
	endtask : wr

	task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar_hit, done;
		int   k;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		for (k = 0; k < 50 && !done; k++) begin
			@(negedge clk);
			ar_hit = arvalid & arready;
			done = rvalid;
			if (done) chk("rdata", ed, rdata);
			if (done) chk("rresp", {30'h0, er}, {30'h0, rresp});
			@(posedge clk);
			if (ar_hit) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
		if (!done) chk("read answer", 32'h1, 32'h0);
	endtask : rd

	// mode fields take writes only with the channel disabled, hence the order
	task setup(input logic [31:0] cfg, input logic [31:0] en);
		wr(32'h4, 32'h0, RESP_OKAY);
		wr(32'h0, cfg, RESP_OKAY);
		wr(32'h4, en, RESP_OKAY);
	endtask : setup

	task drive(input int which, input logic v);
		case (which)
			0: want_two <= v;
			1: want_three <= v;
			default: want_trig <= v;
		endcase
	endtask : drive

	task edges(input int which, input int n);
		repeat (n) begin
			drive(which, 1'b1);
			cyc(4);
			drive(which, 1'b0);
			cyc(4);
		end
		cyc(4);
	endtask : edges

	task t_regs;
		rd(32'h0, 32'h0, RESP_OKAY);
		rd(32'h4, 32'h0, RESP_OKAY);
		rd(32'h8, 32'h0, RESP_OKAY);
		rd(32'hc, 32'h0, RESP_SLVERR);
		wr(32'hc, 32'h0000_ffff, RESP_SLVERR);
		rd(32'h0, 32'h0, RESP_OKAY);
	endtask : t_regs

	task t_layout;
		wr(32'h0, 32'h0000_f6e5, RESP_OKAY);
		rd(32'h0, 32'h0000_f6e5, RESP_OKAY);
		wr(32'h0, 32'h0, RESP_OKAY);
	endtask : t_layout

	// eight qualified edges on each channel for every divider code
	task t_divide;
		int ch, code, b;
		for (ch = 0; ch < 2; ch++) begin
			for (code = 0; code < 4; code++) begin
				if (ch == 0) setup(32'(code << 2) | 32'h1, 32'h100);
				else setup(32'(code << 10) | 32'h100, 32'h1000);
				b = (ch == 0) ? n_two : n_three;
				edges(ch, 8);
				b = ((ch == 0) ? n_two : n_three) - b;
				chk("captures", 32'(8 >> code), 32'(b));
			end
		end
	endtask : t_divide

	// equal samples and sampling divider asked for by each filter code
	int ns[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
	int ds[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};

	// a pulse one sample short must vanish, one sample longer must pass
	task t_filter;
		int c, b;
		for (c = 0; c < 16; c++) begin
			setup(32'(c << 4) | 32'h1, 32'h100);
			cyc(40);
			if (c != 0) begin
				b = n_two;
				drive(0, 1'b1);
				cyc(ds[c] * (ns[c] - 1));
				drive(0, 1'b0);
				cyc(ds[c] * (ns[c] + 2) + 8);
				chk("short pulse", 32'h0, 32'(n_two - b));
			end
			b = n_two;
			drive(0, 1'b1);
			cyc(ds[c] * (ns[c] + 1));
			drive(0, 1'b0);
			cyc(ds[c] * (ns[c] + 2) + 8);
			chk("long pulse", 32'h1, 32'(n_two - b));
		end
	endtask : t_filter

	task t_hold;
		int b;
		setup(32'h5, 32'h100);
		b = n_two;
		edges(0, 1);
		wr(32'h4, 32'h0, RESP_OKAY);
		wr(32'h4, 32'h100, RESP_OKAY);
		edges(0, 1);
		chk("held divider", 32'h0, 32'(n_two - b));
		edges(0, 1);
		chk("held divider", 32'h1, 32'(n_two - b));
	endtask : t_hold

	task t_modes;
		int b;
		setup(32'h1, 32'h100);
		wr(32'h0, 32'h0, RESP_OKAY);
		rd(32'h0, 32'h1, RESP_OKAY);
		b = n_two;
		edges(0, 1);
		chk("own input", 32'h1, 32'(n_two - b));
		setup(32'h0, 32'h100);
		b = n_two;
		edges(0, 1);
		chk("output mode", 32'h0, 32'(n_two - b));
		setup(32'h2, 32'h100);
		b = n_two;
		edges(1, 1);
		chk("neighbour input", 32'h1, 32'(n_two - b));
		setup(32'h3, 32'h100);
		b = n_two;
		edges(2, 1);
		chk("trigger input", 32'h1, 32'(n_two - b));
		setup(32'h1, 32'h300);
		b = n_two;
		drive(0, 1'b1);
		cyc(8);
		chk("falling polarity", 32'h0, 32'(n_two - b));
		drive(0, 1'b0);
		cyc(8);
		chk("falling polarity", 32'h1, 32'(n_two - b));
		// 36 channel two captures wrap to 4, channel three saw 15, pins low
		rd(32'h8, 32'h0000_f400, RESP_OKAY);
	endtask : t_modes

	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		cyc(2);
		t_regs;
		t_layout;
		t_divide;
		t_filter;
		t_hold;
		t_modes;
		stop_test;
	end

	// the filter sweep dominates a run of some 7000 cycles; ample margin
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test;
	end
endmodule : capture_input_filter_prescaler_tb
`default_nettype wire
